//--- hdl/frp_params.svh
// Purpose: Constants for the flash read-parameter register block
// Assumes: Included by bare name from the design modules
// Notes:   Definitions only
`ifndef FRP_PARAMS_SVH
`define FRP_PARAMS_SVH

// ============================================================
// Register fields and reset value
`define FRP_RESET_VALUE       8'h00
`define FRP_PIN_FUNC_BIT      7
`define FRP_DUMMY_HI          6
`define FRP_DUMMY_LO          3
`define FRP_WRAP_EN_BIT       2
`define FRP_BURST_HI_BIT      1
`define FRP_BURST_LO_BIT      0
`define FRP_BURST_BASE_BYTES  7'h08

// ============================================================
// Command opcodes
`define FRP_OP_SET_NV         8'h65
`define FRP_OP_SET_V_A        8'hC0
`define FRP_OP_SET_V_B        8'h63
`define FRP_OP_FAST_READ      8'h0B
`define FRP_OP_FAST_READ_4B   8'h0C
`define FRP_OP_DUAL_OUT       8'h3B
`define FRP_OP_DUAL_OUT_4B    8'h3C
`define FRP_OP_QUAD_OUT       8'h6B
`define FRP_OP_QUAD_OUT_4B    8'h6C
`define FRP_OP_DUAL_IO        8'hBB
`define FRP_OP_DUAL_IO_4B     8'hBC
`define FRP_OP_QUAD_IO        8'hEB
`define FRP_OP_QUAD_IO_4B     8'hEC
`define FRP_OP_FAST_DTR       8'h0D
`define FRP_OP_FAST_DTR_4B    8'h0E
`define FRP_OP_DUAL_DTR       8'hBD
`define FRP_OP_DUAL_DTR_4B    8'hBE
`define FRP_OP_QUAD_DTR       8'hED
`define FRP_OP_QUAD_DTR_4B    8'hEE

// ============================================================
// Default dummy counts and link framing
`define FRP_DUMMY_DEF_WIDE    4'h8
`define FRP_DUMMY_DEF_QUAD    4'h6
`define FRP_DUMMY_DEF_DUAL    4'h4
`define FRP_LINK_OP_BITS      5'h08
`define FRP_LINK_WORD_BITS    5'h10
`define FRP_LINK_STEP_SINGLE  5'h01
`define FRP_LINK_STEP_QUAD    5'h04

`endif

//--- hdl/frp_pkg.sv
// Purpose: Types for the flash read-parameter register block
// Assumes: Constants live in frp_params.svh
// Notes:   One-hot state codes written out
package frp_pkg;

	// ============================================================
	// Enumerations
	typedef enum logic [2:0] {
		FRP_ST_INIT = 3'h1,
		FRP_ST_LOAD = 3'h2,
		FRP_ST_RUN  = 3'h4
	} frp_state_t;

	typedef enum logic [1:0] {
		FRP_PIN_PAUSE = 2'h0,
		FRP_PIN_RESET = 2'h1,
		FRP_PIN_DATA3 = 2'h2
	} frp_pin_func_t;

	// ============================================================
	// Structures
	typedef struct packed {
		logic       is_read;
		logic       lane4_ok;
		logic [3:0] dflt;
	} frp_cmd_info_t;

	typedef struct packed {
		logic       mode_s1;
		logic       mode_s2;
		logic [7:0] shift;
		logic [7:0] opcode;
		logic [7:0] data;
		logic       op_tog;
		logic       word_tog;
	} frp_link_t;

	typedef struct packed {
		frp_state_t    state;
		logic [7:0]    nv;
		logic [7:0]    vol;
		logic          op_s1;
		logic          op_s2;
		logic          op_s3;
		logic          wd_s1;
		logic          wd_s2;
		logic          wd_s3;
		logic          cmd_valid;
		logic          cmd_accept;
		logic [3:0]    dummy;
		logic [7:0]    cmd_op;
		logic          nv_write;
		logic          four_lane;
		frp_pin_func_t pin_func;
	} frp_core_t;

endpackage : frp_pkg

//--- hdl/frp_link.sv
// Purpose: Serial-clock side command capture for the read-parameter block
// Assumes: Idle i_sck pulses while deselected carry the mode; opcode then data
// Notes:   Bytes cross by toggle; capture regs stay put until the next frame
`timescale 1ns/1ns
`include "frp_params.svh"

module frp_link
	import frp_pkg::*;
(
	input  wire logic       i_sck,
	input  wire logic       i_rst_n,
	input  wire logic       i_cs_n,
	input  wire logic [3:0] i_io,
	input  wire logic       i_four_lane_mode,
	output logic      [7:0] o_opcode,
	output logic      [7:0] o_data,
	output logic            o_op_toggle,
	output logic            o_word_toggle
);

	// ============================================================
	// State
	frp_link_t  cur;
	frp_link_t  nxt;
	logic [4:0] count_reg;
	logic [4:0] count_next;
	logic [4:0] step;
	logic [7:0] shifted;

	// ============================================================
	// Next state
	always_comb begin
		nxt        = cur;
		nxt.mode_s1 = i_four_lane_mode;
		nxt.mode_s2 = cur.mode_s1;
		// Four-lane frames carry a nibble per edge on all data lines
		step    = cur.mode_s2 ? `FRP_LINK_STEP_QUAD : `FRP_LINK_STEP_SINGLE;
		shifted = cur.mode_s2 ? {cur.shift[3:0], i_io} : {cur.shift[6:0], i_io[0]};
		count_next = count_reg;
		if (count_reg < `FRP_LINK_WORD_BITS) begin
			count_next = count_reg + step;
			nxt.shift  = shifted;
			if (count_next == `FRP_LINK_OP_BITS) begin
				nxt.opcode = shifted;
				nxt.op_tog = ~cur.op_tog;
			end
			if (count_next == `FRP_LINK_WORD_BITS) begin
				nxt.data     = shifted;
				nxt.word_tog = ~cur.word_tog;
			end
		end
	end

	always_ff @(posedge i_sck or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cur <= '0;
		end else begin
			cur <= nxt;
		end
	end

	// Bit position held at zero while deselected, so idle pulses capture nothing
	always_ff @(posedge i_sck or posedge i_cs_n or negedge i_rst_n) begin
		if (!i_rst_n || i_cs_n) begin
			count_reg <= 5'h00;
		end else begin
			count_reg <= count_next;
		end
	end

	assign o_opcode      = cur.opcode;
	assign o_data        = cur.data;
	assign o_op_toggle   = cur.op_tog;
	assign o_word_toggle = cur.word_tog;

endmodule : frp_link

//--- hdl/frp_top.sv
// Purpose: Read-parameter register of a serial NOR flash, device side
// Assumes: Host commands arrive on the serial link; array image on i_nv_image
// Notes:   Settings drive pin function, dummy count and burst wrap
//
// How it works
// - Keep non-volatile and volatile register copies
// - Power-up loads volatile copy from non-volatile
// - Bit 7 picks pause or reset
// - Quad enable or four-lane forces data line
// - Else dedicated reset pin enabled forces pause
// - Bits 6 to 3 set dummy cycles
// - Nonzero gives N cycles, zero command default
// - Bit 2 enables wrap, else whole array
// - Bits 1:0 select 8/16/32/64 byte burst
// - Set commands update matching copy, all bits
// - Register reads zero by default
// - Default dummy counts per read command
// - Dual-lane double-rate read refused in four-lane
`timescale 1ns/1ns
`include "frp_params.svh"

module frp_top
	import frp_pkg::*;
#(
	parameter bit HAS_DEDICATED_RESET = 1'b0
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_sck,
	input  wire logic       i_cs_n,
	input  wire logic [3:0] i_io,
	input  wire logic       i_quad_enable_flag,
	input  wire logic       i_four_lane_command_mode,
	input  wire logic       i_dedicated_reset_disable,
	input  wire logic [7:0] i_nv_image,
	output logic            o_ready,
	output logic      [7:0] o_read_params,
	output logic      [7:0] o_nv_params,
	output logic            o_nv_write,
	output logic      [7:0] o_nv_data,
	output logic      [1:0] o_pin_function,
	output logic            o_pin_function_select,
	output logic            o_wrap_enable,
	output logic            o_burst_len_hi,
	output logic            o_burst_len_lo,
	output logic      [6:0] o_burst_bytes,
	output logic            o_cmd_valid,
	output logic            o_cmd_accept,
	output logic      [7:0] o_cmd_opcode,
	output logic      [3:0] o_dummy_cycles
);

	// ============================================================
	// Command decode
	// Read commands and their default dummy counts
	function automatic frp_cmd_info_t cmd_info(
		input logic [7:0] op,
		input logic       four_lane
	);
		frp_cmd_info_t info;
		info = '0;
		case (op)
			`FRP_OP_FAST_READ, `FRP_OP_FAST_READ_4B,
			`FRP_OP_FAST_DTR, `FRP_OP_FAST_DTR_4B: begin
				info.is_read  = 1'b1;
				info.lane4_ok = 1'b1;
				info.dflt     = four_lane ? `FRP_DUMMY_DEF_QUAD
				                          : `FRP_DUMMY_DEF_WIDE;
			end
			`FRP_OP_DUAL_OUT, `FRP_OP_DUAL_OUT_4B,
			`FRP_OP_QUAD_OUT, `FRP_OP_QUAD_OUT_4B: begin
				info.is_read = 1'b1;
				info.dflt    = `FRP_DUMMY_DEF_WIDE;
			end
			`FRP_OP_DUAL_IO, `FRP_OP_DUAL_IO_4B,
			`FRP_OP_DUAL_DTR, `FRP_OP_DUAL_DTR_4B: begin
				// No four-lane form exists for dual-address reads
				info.is_read = 1'b1;
				info.dflt    = `FRP_DUMMY_DEF_DUAL;
			end
			`FRP_OP_QUAD_IO, `FRP_OP_QUAD_IO_4B,
			`FRP_OP_QUAD_DTR, `FRP_OP_QUAD_DTR_4B: begin
				info.is_read  = 1'b1;
				info.lane4_ok = 1'b1;
				info.dflt     = `FRP_DUMMY_DEF_QUAD;
			end
			default: begin
				info = '0;
			end
		endcase
		return info;
	endfunction : cmd_info

	function automatic logic is_set_volatile(input logic [7:0] op);
		return (op == `FRP_OP_SET_V_A) || (op == `FRP_OP_SET_V_B);
	endfunction : is_set_volatile

	// ============================================================
	// Link side
	frp_core_t  cur;
	frp_core_t  nxt;
	logic [7:0] link_opcode;
	logic [7:0] link_data;
	logic       link_op_tog;
	logic       link_word_tog;

	frp_link u_link (
		.i_sck            (i_sck),
		.i_rst_n          (i_rst_n),
		.i_cs_n           (i_cs_n),
		.i_io             (i_io),
		.i_four_lane_mode (cur.four_lane),
		.o_opcode         (link_opcode),
		.o_data           (link_data),
		.o_op_toggle      (link_op_tog),
		.o_word_toggle    (link_word_tog)
	);

	// ============================================================
	// Core state
	frp_cmd_info_t info;
	logic          op_event;
	logic          word_event;
	logic [3:0]    dummy_field;
	logic          pin_as_data;
	logic          pin_forced_pause;

	// ============================================================
	// Next state
	always_comb begin
		nxt         = cur;
		// Toggles from the serial clock pass two flops before use
		nxt.op_s1   = link_op_tog;
		nxt.op_s2   = cur.op_s1;
		nxt.op_s3   = cur.op_s2;
		nxt.wd_s1   = link_word_tog;
		nxt.wd_s2   = cur.wd_s1;
		nxt.wd_s3   = cur.wd_s2;
		nxt.four_lane = i_four_lane_command_mode;
		nxt.cmd_valid = 1'b0;
		nxt.nv_write  = 1'b0;
		op_event    = cur.op_s2 ^ cur.op_s3;
		word_event  = cur.wd_s2 ^ cur.wd_s3;
		dummy_field = cur.vol[`FRP_DUMMY_HI:`FRP_DUMMY_LO];
		info        = cmd_info(link_opcode, cur.four_lane);

		case (cur.state)
			FRP_ST_INIT: begin
				// Array image is caught after reset release, not under it
				nxt.nv    = i_nv_image;
				nxt.state = FRP_ST_LOAD;
			end
			FRP_ST_LOAD: begin
				nxt.vol   = cur.nv;
				nxt.state = FRP_ST_RUN;
			end
			FRP_ST_RUN: begin
				if (op_event) begin
					nxt.cmd_valid  = 1'b1;
					nxt.cmd_op     = link_opcode;
					nxt.cmd_accept = info.is_read &&
					                 (!cur.four_lane || info.lane4_ok);
					if (dummy_field != 4'h0) begin
						nxt.dummy = dummy_field;
					end else begin
						nxt.dummy = info.dflt;
					end
				end
				if (word_event) begin
					if (link_opcode == `FRP_OP_SET_NV) begin
						nxt.nv       = link_data;
						nxt.nv_write = 1'b1;
					end else if (is_set_volatile(link_opcode)) begin
						nxt.vol = link_data;
					end
				end
			end
			default: begin
				nxt.state = FRP_ST_INIT;
			end
		endcase

		// Shared pin function, highest priority first
		pin_as_data      = i_quad_enable_flag || i_four_lane_command_mode;
		pin_forced_pause = HAS_DEDICATED_RESET && !i_dedicated_reset_disable;
		if (pin_as_data) begin
			nxt.pin_func = FRP_PIN_DATA3;
		end else if (pin_forced_pause) begin
			nxt.pin_func = FRP_PIN_PAUSE;
		end else if (cur.vol[`FRP_PIN_FUNC_BIT]) begin
			nxt.pin_func = FRP_PIN_RESET;
		end else begin
			nxt.pin_func = FRP_PIN_PAUSE;
		end
	end

	// ============================================================
	// Registers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cur       <= '0;
			cur.state <= FRP_ST_INIT;
			cur.nv    <= `FRP_RESET_VALUE;
			cur.vol   <= `FRP_RESET_VALUE;
		end else begin
			cur <= nxt;
		end
	end

	// ============================================================
	// Outputs
	assign o_ready               = (cur.state == FRP_ST_RUN);
	assign o_read_params         = cur.vol;
	assign o_nv_params           = cur.nv;
	assign o_nv_write            = cur.nv_write;
	assign o_nv_data             = cur.nv;
	assign o_pin_function        = cur.pin_func;
	assign o_pin_function_select = cur.vol[`FRP_PIN_FUNC_BIT];
	assign o_wrap_enable         = cur.vol[`FRP_WRAP_EN_BIT];
	assign o_burst_len_hi        = cur.vol[`FRP_BURST_HI_BIT];
	assign o_burst_len_lo        = cur.vol[`FRP_BURST_LO_BIT];
	// Burst length code doubles from 8 bytes; wrap enable decides if it is used
	assign o_burst_bytes         = `FRP_BURST_BASE_BYTES <<
	                               cur.vol[`FRP_BURST_HI_BIT:`FRP_BURST_LO_BIT];
	assign o_cmd_valid           = cur.cmd_valid;
	assign o_cmd_accept          = cur.cmd_accept;
	assign o_cmd_opcode          = cur.cmd_op;
	assign o_dummy_cycles        = cur.dummy;

endmodule : frp_top

//--- verif/frp_top_monitor.sv
// Purpose: Port checker for the read-parameter block
// Assumes: Core-domain level inputs change only between frames
// Notes:   Bound to every frp_top instance
`timescale 1ns/1ns
module frp_top_monitor
	import frp_pkg::*;
#(
	parameter bit HAS_DEDICATED_RESET = 1'b0
) (
	input wire logic       i_clk,
	input wire logic       i_rst_n,
	input wire logic       i_quad_enable_flag,
	input wire logic       i_four_lane_command_mode,
	input wire logic       i_dedicated_reset_disable,
	input wire logic       o_ready,
	input wire logic [7:0] o_read_params,
	input wire logic [7:0] o_nv_params,
	input wire logic       o_nv_write,
	input wire logic [7:0] o_nv_data,
	input wire logic [1:0] o_pin_function,
	input wire logic       o_wrap_enable,
	input wire logic [6:0] o_burst_bytes,
	input wire logic       o_cmd_valid,
	input wire logic       o_cmd_accept,
	input wire logic [7:0] o_cmd_opcode,
	input wire logic [3:0] o_dummy_cycles
);
	// ============================================================
	// Sequences and assertions
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_nv_pulse;
		o_nv_write ##1 !o_nv_write;
	endsequence
	// Pin function lags the copy by one edge, so only judge a settled copy
	sequence s_settled;
		o_ready && $past(o_ready) && $stable(o_read_params);
	endsequence
	a_power_load: assert property ($rose(o_ready) |-> o_read_params == o_nv_params)
		else $error("volatile copy not loaded at power-up");
	a_nv_pulse: assert property (o_nv_write |->
		(o_nv_data == o_nv_params && o_cmd_opcode == 8'h65) ##0 s_nv_pulse)
		else $error("bad non-volatile write pulse");
	a_nv_change: assert property (o_ready && $changed(o_nv_params) |->
		o_nv_write && $stable(o_read_params))
		else $error("non-volatile change leaked or unreported");
	a_vol_cmd: assert property ($past(o_ready) && $changed(o_read_params) |->
		o_cmd_opcode inside {8'hC0, 8'h63})
		else $error("volatile copy changed without set command");
	a_pin_select: assert property (s_settled ##0 (!$past(i_quad_enable_flag)
		&& !$past(i_four_lane_command_mode)) |-> o_pin_function ==
		((HAS_DEDICATED_RESET && !$past(i_dedicated_reset_disable)) ? 2'h0
		: {1'b0, o_read_params[7]}))
		else $error("pin function wrong");
	a_pin_data: assert property (o_ready && $past(o_ready) && ($past(i_quad_enable_flag)
		|| $past(i_four_lane_command_mode)) |-> o_pin_function == 2'h2)
		else $error("pin not data line three");
	a_burst_wrap: assert property (s_settled |-> o_wrap_enable == o_read_params[2]
		&& o_burst_bytes == (o_read_params[1] ? (o_read_params[0] ? 7'h40 : 7'h20)
		: (o_read_params[0] ? 7'h10 : 7'h08)))
		else $error("wrap decode wrong");
	a_dummy_set: assert property (o_cmd_valid && o_read_params[6:3] != 4'h0 |->
		o_dummy_cycles == o_read_params[6:3])
		else $error("dummy count not from field");
	a_dummy_dflt: assert property (o_cmd_valid && o_read_params[6:3] == 4'h0 &&
		o_cmd_opcode == 8'h0B |-> o_dummy_cycles ==
		($past(i_four_lane_command_mode) ? 4'h6 : 4'h8))
		else $error("default dummy count wrong");
	a_dtr_refused: assert property (o_cmd_valid && $past(i_four_lane_command_mode) &&
		o_cmd_opcode inside {8'hBD, 8'hBE} |-> !o_cmd_accept)
		else $error("double-rate dual read accepted in four-lane");
endmodule : frp_top_monitor

bind frp_top frp_top_monitor #(.HAS_DEDICATED_RESET(HAS_DEDICATED_RESET)) frp_top_monitor_i (
	.i_clk, .i_rst_n, .i_quad_enable_flag, .i_four_lane_command_mode,
	.i_dedicated_reset_disable, .o_ready, .o_read_params, .o_nv_params, .o_nv_write,
	.o_nv_data, .o_pin_function, .o_wrap_enable, .o_burst_bytes, .o_cmd_valid,
	.o_cmd_accept, .o_cmd_opcode, .o_dummy_cycles);

//--- verif/frp_host_model.sv
// Purpose: Host controller model driving the serial link
// Assumes: 48 ns serial clock, two deselected pulses lead each frame
// Notes:   Lanes show the inverse of the last value once deselected
`timescale 1ns/1ns
module frp_host_model (
	output logic       o_sck,
	output logic       o_cs_n,
	output logic [3:0] o_io
);
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_io = 4'h0;
	end
	// Slow clock keeps every dummy setting legal; host never turns lanes round
	task automatic frame(input logic [7:0] op, input logic [7:0] d, input logic q);
		logic [15:0] w;
		int          n;
		w = {op, d};
		n = q ? 4 : 16;
		// Mode reaches the link only on link-clock edges
		repeat (2) begin
			#24 o_sck = 1'b1;
			#24 o_sck = 1'b0;
		end
		o_cs_n = 1'b0;
		for (int k = 0; k < n; k++) begin
			o_io = q ? w[15:12] : {~o_io[3:1], w[15]};
			w = q ? w << 4 : w << 1;
			#24 o_sck = 1'b1;
			#24 o_sck = 1'b0;
		end
		#24 o_cs_n = 1'b1;
		o_io = ~o_io;
	endtask : frame
endmodule : frp_host_model

//--- verif/testbench.sv
// Purpose: Self-checking bench for the read-parameter block
// Assumes: Settled outputs sampled 8 core cycles after each frame
// Notes:   Dedicated reset pin variant, so both pause paths are seen
`timescale 1ns/1ns
module testbench;
	logic       i_clk, i_rst_n, i_sck, i_cs_n;
	logic [3:0] i_io;
	logic       i_quad_enable_flag, i_four_lane_command_mode, i_dedicated_reset_disable;
	logic [7:0] i_nv_image, o_read_params, o_nv_params, o_cmd_opcode;
	logic       o_ready, o_wrap_enable, o_cmd_accept, o_pin_function_select;
	logic       o_burst_len_hi, o_burst_len_lo;
	logic [1:0] o_pin_function;
	logic [6:0] o_burst_bytes;
	logic [3:0] o_dummy_cycles;
	logic [7:0] dops [4] = '{8'h0B, 8'hBB, 8'hEB, 8'h6B};
	logic [3:0] dexp [4] = '{4'h8, 4'h4, 4'h6, 4'h8};
	int         n_mismatch = 0;
	int         n_compared = 0;
	// ============================================================
	// Clock, partner, design
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	frp_host_model host_i (.o_sck(i_sck), .o_cs_n(i_cs_n), .o_io(i_io));
	frp_top #(.HAS_DEDICATED_RESET(1'b1)) frp_top_i (
		.i_clk, .i_rst_n, .i_sck, .i_cs_n, .i_io, .i_quad_enable_flag,
		.i_four_lane_command_mode, .i_dedicated_reset_disable, .i_nv_image, .o_ready,
		.o_read_params, .o_nv_params, .o_nv_write(), .o_nv_data(), .o_pin_function,
		.o_pin_function_select, .o_wrap_enable, .o_burst_len_hi, .o_burst_len_lo,
		.o_burst_bytes, .o_cmd_valid(), .o_cmd_accept, .o_cmd_opcode, .o_dummy_cycles);
	// ============================================================
	// Tasks
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic send(input logic [7:0] op, input logic [7:0] d);
		host_i.frame(op, d, i_four_lane_command_mode);
		repeat (8) @(posedge i_clk);
		#1;
	endtask : send
	task automatic power_up(input logic [7:0] img);
		@(posedge i_clk) #1;
		i_rst_n = 1'b0;
		i_nv_image = img;
		repeat (2) @(posedge i_clk);
		#1 chk(o_read_params, 8'h00);
		i_rst_n = 1'b1;
		repeat (4) @(posedge i_clk);
		#1 chk({7'h0, o_ready}, 8'h01);
		chk(o_read_params, img);
	endtask : power_up
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : conclude
	initial begin
		#100000;
		n_mismatch++;
		conclude;
	end
	// ============================================================
	// Tests
	initial begin
		i_rst_n = 1'b0;
		i_quad_enable_flag = 1'b0;
		i_four_lane_command_mode = 1'b0;
		i_dedicated_reset_disable = 1'b1;
		i_nv_image = 8'h00;
		power_up(8'h5A);
		chk(o_nv_params, 8'h5A);
		send(8'h0B, 8'h00);
		chk({4'h0, o_dummy_cycles}, 8'h0B);
		chk({7'h0, o_cmd_accept}, 8'h01);
		send(8'hC0, 8'h84);
		chk(o_read_params, 8'h84);
		chk(o_nv_params, 8'h5A);
		chk({7'h0, o_wrap_enable}, 8'h01);
		chk({6'h0, o_pin_function}, 8'h01);
		chk({7'h0, o_pin_function_select}, 8'h01);
		i_dedicated_reset_disable = 1'b0;
		repeat (2) @(posedge i_clk);
		#1 chk({6'h0, o_pin_function}, 8'h00);
		i_quad_enable_flag = 1'b1;
		repeat (2) @(posedge i_clk);
		#1 chk({6'h0, o_pin_function}, 8'h02);
		i_quad_enable_flag = 1'b0;
		i_dedicated_reset_disable = 1'b1;
		$display("test pin function done");
		for (int k = 0; k < 4; k++) begin
			send(k[0] ? 8'h63 : 8'hC0, 8'h04 | 8'(k));
			chk({1'h0, o_burst_bytes}, 8'h08 << k);
			chk({6'h0, o_burst_len_hi, o_burst_len_lo}, 8'(k));
		end
		send(8'hC0, 8'h03);
		chk({7'h0, o_wrap_enable}, 8'h00);
		foreach (dops[k]) begin
			send(dops[k], 8'h00);
			chk({4'h0, o_dummy_cycles}, {4'h0, dexp[k]});
		end
		$display("test dummy and wrap done");
		i_four_lane_command_mode = 1'b1;
		repeat (4) @(posedge i_clk);
		send(8'h0B, 8'h00);
		chk({4'h0, o_dummy_cycles}, 8'h06);
		chk({7'h0, o_cmd_accept}, 8'h01);
		send(8'hBD, 8'h00);
		chk({7'h0, o_cmd_accept}, 8'h00);
		chk(o_cmd_opcode, 8'hBD);
		chk({6'h0, o_pin_function}, 8'h02);
		send(8'hC0, 8'h7B);
		chk(o_read_params, 8'h7B);
		i_four_lane_command_mode = 1'b0;
		repeat (4) @(posedge i_clk);
		send(8'h0B, 8'h00);
		chk({4'h0, o_dummy_cycles}, 8'h0F);
		$display("test four-lane done");
		send(8'h65, 8'hC8);
		chk(o_nv_params, 8'hC8);
		chk(o_read_params, 8'h7B);
		power_up(8'hC8);
		send(8'h0B, 8'h00);
		chk({4'h0, o_dummy_cycles}, 8'h09);
		$display("test non-volatile done");
		conclude;
	end
endmodule : testbench
